// ### core/gpid_defs.vh
`ifndef GPID_DEFS_VH
`define GPID_DEFS_VH
// Register offsets (byte addresses, word aligned)
`define GPID_OFF_RAW 8'h00
`define GPID_OFF_MIS 8'h04
`define GPID_OFF_EN 8'h08
`define GPID_OFF_CLR 8'h0c
`define GPID_OFF_TYPE_SEL 8'h10
`define GPID_OFF_TYPE_SET 8'h14
`define GPID_OFF_TYPE_RD 8'h18
`define GPID_OFF_PAD_SET 8'h1c
`define GPID_OFF_PAD_RD 8'h20
`define GPID_OFF_PIN_RD 8'h24
// Detection type codes, bits 2:0 of a type word
`define GPID_TYPE_FALL 3'h0
`define GPID_TYPE_RISE 3'h1
`define GPID_TYPE_BOTH 3'h2
`define GPID_TYPE_LOW 3'h3
`define GPID_TYPE_HIGH 3'h4
// Discrete flag position in type word
`define GPID_DISC_BIT 3
// Pad word layout: strength 3:0, pin type 7:4
`define GPID_PAD_W 8
// Source bit of DMA activity
`define GPID_DMA_BIT 8
// Reset values
`define GPID_TYPE_RST 3'h0
`define GPID_PAD_RST 8'h00
`endif

// ### core/gpid_pin_detect.v
`timescale 1ns/10ps
`default_nettype none
`include "gpid_defs.vh"
// One pin: three-stage synchroniser plus edge or level detection
module gpid_pin_detect (
  input wire core_clk_i,
  input wire arst_n_i,
  input wire pin_i,
  input wire [2:0] type_i,
  input wire clear_i,
  output wire active_o,
  output wire level_o
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  reg lvl_reg;
  reg lat_reg;
  wire rise;
  wire fall;
  wire hit_edge;
  wire is_level;
  // Synchroniser; first stage feeds only the second
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      lvl_reg <= 1'b0;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Change counts once stages two and three agree
      if (s2_reg == s3_reg) begin
        lvl_reg <= s3_reg;
      end
    end
  end
  assign rise = (s2_reg == s3_reg) && s3_reg && !lvl_reg;
  assign fall = (s2_reg == s3_reg) && !s3_reg && lvl_reg;
  assign is_level = (type_i == `GPID_TYPE_LOW) || (type_i == `GPID_TYPE_HIGH);
  assign hit_edge = ((type_i == `GPID_TYPE_FALL) && fall) ||
                    ((type_i == `GPID_TYPE_RISE) && rise) ||
                    ((type_i == `GPID_TYPE_BOTH) && (rise || fall));
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lat_reg <= 1'b0;
    end else if (hit_edge) begin
      lat_reg <= 1'b1;
    end else if (clear_i || is_level) begin
      lat_reg <= 1'b0;
    end
  end
  assign active_o = is_level ? ((type_i == `GPID_TYPE_HIGH) ? lvl_reg : !lvl_reg) : lat_reg;
  assign level_o = lvl_reg;
endmodule
`default_nettype wire

// ### core/gpid_port_irq.v
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "gpid_defs.vh"
module gpid_port_irq #(
  parameter PINS = 8,
  parameter HAS_DISCRETE = 1
) (
  input wire core_clk_i,
  input wire arst_n_i,
  input wire [PINS-1:0] pin_i,
  input wire dma_event_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  output wire irq_o,
  output wire [PINS-1:0] pin_irq_o,
  output wire [PINS-1:0] pad_pull_up_o,
  output wire [PINS-1:0] pad_pull_dn_o
);
  localparam SRC = PINS + 1;
  // ****************************************
  // Registers
  // ****************************************
  reg [SRC-1:0] enable_reg;
  reg [PINS-1:0] pin_select_mask_reg;
  reg [2:0] type_reg [0:PINS-1];
  reg [PINS-1:0] disc_reg;
  reg [`GPID_PAD_W-1:0] pad_reg [0:PINS-1];
  reg dma_lat_reg;
  wire [SRC-1:0] raw_status;
  wire [SRC-1:0] masked_status;
  wire [PINS-1:0] pin_active;
  wire [PINS-1:0] pin_level;
  wire [SRC-1:0] source_select_mask;
  wire clr_wr;
  wire discrete_on;
  integer i;
  // Decode used by every write path
  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction
  assign clr_wr = wr_i && hit(addr_i, `GPID_OFF_CLR);
  assign source_select_mask = clr_wr ? wdata_i[SRC-1:0] : {SRC{1'b0}};
  // ****************************************
  // Per-pin detectors
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < PINS; g = g + 1) begin : pin_gen
      gpid_pin_detect u_det (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(pin_i[g]),
        .type_i(type_reg[g]),
        .clear_i(source_select_mask[g]),
        .active_o(pin_active[g]),
        .level_o(pin_level[g])
      );
      // Pull settings are the only pad effect on inputs
      assign pad_pull_up_o[g] = pad_reg[g][4];
      assign pad_pull_dn_o[g] = pad_reg[g][5];
    end
  endgenerate
  // DMA activity latched; set wins over clear
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dma_lat_reg <= 1'b0;
    end else if (dma_event_i) begin
      dma_lat_reg <= 1'b1;
    end else if (source_select_mask[`GPID_DMA_BIT]) begin
      dma_lat_reg <= 1'b0;
    end
  end
  assign raw_status = {dma_lat_reg, pin_active};
  assign masked_status = raw_status & enable_reg;
  // Discrete mode is a port-wide setting mirrored in every pin word
  assign discrete_on = (HAS_DISCRETE != 0) && disc_reg[0];
  // summary routed onto pin 0 line
  assign pin_irq_o = discrete_on ? masked_status[PINS-1:0] :
                     {{(PINS-1){1'b0}}, |masked_status};
  assign irq_o = |masked_status;
  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      enable_reg <= {SRC{1'b0}};
      pin_select_mask_reg <= {PINS{1'b0}};
      disc_reg <= {PINS{1'b0}};
      for (i = 0; i < PINS; i = i + 1) begin
        type_reg[i] <= `GPID_TYPE_RST;
        pad_reg[i] <= `GPID_PAD_RST;
      end
    end else if (wr_i) begin
      if (hit(addr_i, `GPID_OFF_EN)) begin
        enable_reg <= wdata_i[SRC-1:0];
      end
      if (hit(addr_i, `GPID_OFF_TYPE_SEL)) begin
        pin_select_mask_reg <= wdata_i[PINS-1:0];
      end
      for (i = 0; i < PINS; i = i + 1) begin
        if (wdata_i[8 + i] && hit(addr_i, `GPID_OFF_TYPE_SET)) begin
          if (wdata_i[2:0] <= `GPID_TYPE_HIGH) begin
            type_reg[i] <= wdata_i[2:0];
          end
        end
        if (wdata_i[8 + i] && hit(addr_i, `GPID_OFF_PAD_SET)) begin
          pad_reg[i] <= wdata_i[`GPID_PAD_W-1+16:16];
        end
      end
      if (hit(addr_i, `GPID_OFF_TYPE_SET) && (HAS_DISCRETE != 0)) begin
        disc_reg <= {PINS{wdata_i[`GPID_DISC_BIT]}};
      end
    end
  end
  // ****************************************
  // Register reads, data one cycle later
  // ****************************************
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= 32'h0000_0000;
      case (addr_i)
        `GPID_OFF_RAW: rdata_o[SRC-1:0] <= raw_status;
        `GPID_OFF_MIS: rdata_o[SRC-1:0] <= masked_status;
        `GPID_OFF_EN: rdata_o[SRC-1:0] <= enable_reg;
        `GPID_OFF_TYPE_SEL: rdata_o[PINS-1:0] <= pin_select_mask_reg;
        `GPID_OFF_TYPE_RD: rdata_o <= type_word(pin_select_mask_reg);
        `GPID_OFF_PAD_RD: rdata_o <= pad_word(pin_select_mask_reg);
        `GPID_OFF_PIN_RD: rdata_o[PINS-1:0] <= pin_level;
        default: rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end
  // Lowest selected pin picks the readback word
  function [31:0] type_word;
    input [PINS-1:0] sel;
    integer k;
    reg done;
    begin
      type_word = 32'h0000_0000;
      done = 1'b0;
      for (k = 0; k < PINS; k = k + 1) begin
        if (sel[k] && !done) begin
          type_word[2:0] = type_reg[k];
          type_word[`GPID_DISC_BIT] = disc_reg[k];
          done = 1'b1;
        end
      end
    end
  endfunction
  function [31:0] pad_word;
    input [PINS-1:0] sel;
    integer k;
    reg done;
    begin
      pad_word = 32'h0000_0000;
      done = 1'b0;
      for (k = 0; k < PINS; k = k + 1) begin
        if (sel[k] && !done) begin
          pad_word[`GPID_PAD_W-1:0] = pad_reg[k];
          done = 1'b1;
        end
      end
    end
  endfunction
endmodule
`default_nettype wire

// ### dv/gpid_port_irq_sva.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level checks on the interrupt detect block
module gpid_chk (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic dma_event_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic irq_o,
  input wire logic [7:0] pin_irq_o,
  input wire logic [7:0] pad_pull_up_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside its slot");
  AST_LINE_IRQ: assert property (pin_irq_o != 8'h0 |-> irq_o)
    else $error("pin line without port interrupt");
  AST_EN_OFF: assert property (wr_i && addr_i == 8'h08 && wdata_i[8:0] == 9'h0 |=> !irq_o)
    else $error("interrupt with all sources disabled");
  AST_EN_BACK: assert property (wr_i && addr_i == 8'h08 ##2 rd_i && addr_i == 8'h08
    |=> rdata_o[8:0] == $past(wdata_i[8:0], 3)) else $error("enable readback wrong");
  AST_MIS_VIEW: assert property (rd_i && addr_i == 8'h04
    |=> (rdata_o != 32'h0) == $past(irq_o)) else $error("masked view disagrees with irq");
  AST_DMA_SET: assert property (dma_event_i ##1 !wr_i ##1 rd_i && addr_i == 8'h00
    |=> rdata_o[8]) else $error("dma source not set");
  AST_UNMAP: assert property (rd_i && addr_i > 8'h24 |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  // Pull-up follows pad word bit 4 on selected pins only
  AST_PAD: assert property (wr_i && addr_i == 8'h1c |=>
    (pad_pull_up_o & $past(wdata_i[15:8])) == ({8{$past(wdata_i[20])}} & $past(wdata_i[15:8])))
    else $error("pad pull-up wrong");
  cover property (rd_i && addr_i == 8'h04 ##1 rdata_o != 32'h0);
  cover property (pin_irq_o == 8'h01);
  cover property (pin_irq_o == 8'h08);
endmodule
bind gpid_port_irq gpid_chk u_chk (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
  .dma_event_i(dma_event_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .irq_o(irq_o), .pin_irq_o(pin_irq_o), .pad_pull_up_o(pad_pull_up_o));
`default_nettype wire

// ### dv/gpid_far_model.sv
`timescale 1ns/10ps
`default_nettype none
// Pins, DMA activity and the interrupt controller view
module gpid_far_model (
  input wire logic core_clk_i,
  input wire logic [7:0] line_i,
  output var logic [7:0] pin_o,
  output var logic dma_o,
  output wire logic ctrl_irq_o
);
  // controller listens to pin-0 line only
  assign ctrl_irq_o = line_i[0];
  initial begin
    pin_o = 8'h0;
    dma_o = 1'b0;
  end
  task automatic drive(input logic [7:0] v);
    @(posedge core_clk_i);
    pin_o <= v;
  endtask
  // One-cycle activity pulse, as the port expects
  task automatic dma_pulse();
    @(posedge core_clk_i);
    dma_o <= 1'b1;
    @(posedge core_clk_i);
    dma_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### dv/test_gpio_pin_interrupt_detect.sv
`timescale 1ns/10ps
`default_nettype none
module test_gpio_pin_interrupt_detect;
  logic core_clk_i, arst_n_i, wr_i, rd_i, irq_o, dma, ctrl_irq;
  logic [7:0] pins, addr_i, pin_irq_o, pull_up, pull_dn;
  logic [31:0] wdata_i, d, m;
  int err_count, comparisons, n, t, en;
  int rise_tab[5] = '{0, 1, 1, 0, 1};
  int fall_tab[5] = '{1, 0, 1, 1, 0};
  wire logic [31:0] rdata_o_w;
  gpid_port_irq dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .pin_i(pins),
    .dma_event_i(dma), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o_w), .irq_o(irq_o), .pin_irq_o(pin_irq_o), .pad_pull_up_o(pull_up),
    .pad_pull_dn_o(pull_dn));
  gpid_far_model far (.core_clk_i(core_clk_i), .line_i(pin_irq_o), .pin_o(pins),
    .dma_o(dma), .ctrl_irq_o(ctrl_irq));
  // Free-running 10 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic results();
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    // Let the written register settle before anyone looks at outputs
    @(negedge core_clk_i);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    @(negedge core_clk_i);
    v = rdata_o_w;
  endtask
  // Watchdog, so a stuck run still reaches the verdict
  initial begin
    repeat (20000) @(posedge core_clk_i);
    err_count++;
    results();
  end
  initial begin
    {arst_n_i, wr_i, rd_i} = 3'h0;
    addr_i = 8'h0;
    wdata_i = 32'h0;
    void'($urandom(17811));
    repeat (20) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    en = $urandom_range(511, 0);
    wr(8'h08, en);
    rd(8'h08, d); check(d, en);
    rd(8'h28, d); check(d, 0);
    // Each type on a random pin, pins held still while retyping
    for (t = 0; t < 5; t++) begin
      n = $urandom_range(7, 0);
      en = $urandom_range(511, 0);
      wr(8'h08, en);
      wr(8'h14, (32'h100 << n) | t);
      wr(8'h10, 32'h1 << n);
      rd(8'h18, d); check(d, t);
      wr(8'h0c, 32'h1ff);
      far.drive(8'h1 << n);
      repeat (8) @(posedge core_clk_i);
      rd(8'h00, d); check(d[n], rise_tab[t]);
      rd(8'h04, m); check(m, d & en);
      check(irq_o, (d & en) != 0);
      wr(8'h0c, 32'h1ff);
      far.drive(8'h0);
      repeat (8) @(posedge core_clk_i);
      rd(8'h00, d); check(d[n], fall_tab[t]);
    end
    far.dma_pulse();
    rd(8'h00, d); check(d[8], 1);
    wr(8'h08, 32'h100);
    wr(8'h0c, 32'h0ff);
    rd(8'h00, d); check(d[8], 1);
    check({ctrl_irq, pin_irq_o}, 9'h101);
    wr(8'h0c, 32'h100);
    rd(8'h00, d); check(d[8], 0);
    // Pin 3 high level with discrete lines
    wr(8'h14, 32'h80c);
    wr(8'h10, 32'h8);
    rd(8'h18, d); check(d, 32'hc);
    far.drive(8'h08);
    repeat (8) @(posedge core_clk_i);
    wr(8'h08, 32'h8);
    check(pin_irq_o, 8'h08);
    wr(8'h08, 32'h0);
    check({irq_o, pin_irq_o}, 9'h0);
    m = $urandom;
    wr(8'h1c, {8'h0, m[7:0], 16'hff00});
    check({pull_dn, pull_up}, {{8{m[5]}}, {8{m[4]}}});
    rd(8'h20, d); check(d, {24'h0, m[7:0]});
    rd(8'h24, d); check(d, 32'h8);
    results();
  end
endmodule
`default_nettype wire
